// ### hw/pump_protect_trip_restart.v
// Run permit, protection trip and automatic restart logic for a pump motor.
//
// What this block does
// - Run request high (tied to 24 V) means start; low (open) means stop.
// - Motor runs whenever start is present and no alarm stands, at once, with no warning.
// - Protection trip can be assigned to input A or input B by function setting.
// - Function code 7 in an input's function setting enables protection trip.
// - Delay timer starts when an enabled protection input goes open.
// - Input open for the whole delay stops the motor and raises alarm 60.
// - Input reclosing before the delay ends raises no alarm.
// - Automatic restart happens only when policy and interval allow it.
// - Restart allowance defaults to three; zero means manual reset only.
// - Wait the restart interval, 30 s default, before each restart attempt.
// - Trip-lock alarms never restart automatically under the policy.
`include "pump_protect_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module pump_protect_trip_restart #(
    parameter [31:0] TICK_CYCLES = `TICK_CYCLES
) (
    input wire core_clk,
    input wire rst_n,
    input wire run_request_input,
    input wire protect_input_a,
    input wire protect_input_b,
    input wire trip_lock_alarm,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    output reg motor_run,
    output reg alarm_active,
    output reg [7:0] alarm_code,
    output reg irq
);

    // Trip states: idle runs on request, tripped waits to restart, locked waits for reset.
    // The state code is shown in the status word, so the codes must stay as they are.
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_TRIPPED = 2'h1;
    localparam [1:0] ST_LOCKED = 2'h2;

    // Divider state for the one-second enable pulse.
    reg [31:0] tick_cnt_ff;
    reg tick_ff;

    // Settings written by software.
    reg [15:0] ctrl_ff;
    reg [15:0] delay_sec_ff;
    reg [15:0] restart_sec_ff;

    // Interrupt status and mask, one bit per event.
    reg [2:0] irq_stat_ff;
    reg [2:0] irq_mask_ff;

    // Trip state and the events and alarm number it produces.
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [2:0] nxt_event;
    reg [7:0] nxt_alarm_code;

    // Protection delay and restart interval timers, counted in seconds.
    // Both count one-second ticks and stop once their limit is reached.
    reg [15:0] delay_cnt_ff;
    reg [15:0] restart_cnt_ff;
    reg delay_run_ff;

    // Automatic restarts used since the last manual reset.
    reg [3:0] attempts_ff;

    // Status word assembled for the read port.
    wire [15:0] status_word;

    // True for a write strobe aimed at one register offset.
    function write_hit;
        input wr;
        input [3:0] addr;
        input [3:0] want;
        begin
            write_hit = wr && (addr == want);
        end
    endfunction

    // True once a seconds counter has reached its programmed limit.
    // A limit of zero is reached at once, so a zero delay trips on the next edge.
    function sec_reached;
        input [15:0] cnt;
        input [15:0] limit;
        begin
            sec_reached = (cnt >= limit);
        end
    endfunction

    // True when a function setting selects the protection trip.
    function is_protect;
        input [3:0] func;
        begin
            is_protect = (func == `FUNC_PROTECT);
        end
    endfunction

    // Manual reset is a write-one bit of the control word and is never stored.
    wire wr_ctrl = write_hit(reg_wr, reg_addr, `REG_CTRL);
    wire manual_reset = wr_ctrl && reg_wdata[`CTRL_MANUAL_RESET];
    wire [3:0] restart_max = ctrl_ff[`CTRL_MAX_LSB +: 4];

    // Any enabled protection input that is open reports a fault.
    // An input whose function setting is not the trip is ignored however it is wired.
    wire open_a = is_protect(ctrl_ff[`CTRL_FUNC_A_LSB +: 4]) && !protect_input_a;
    wire open_b = is_protect(ctrl_ff[`CTRL_FUNC_B_LSB +: 4]) && !protect_input_b;
    wire protect_open = open_a || open_b;
    wire delay_done = delay_run_ff && sec_reached(delay_cnt_ff, delay_sec_ff);
    wire restart_due = sec_reached(restart_cnt_ff, restart_sec_ff);
    // A zero allowance means manual reset only; otherwise restarts stop at the allowance.
    wire may_restart = (restart_max != 4'h0) && (attempts_ff < restart_max);

    // Status fields: attempts, state, delay running, input open, alarm and motor.
    assign status_word = {attempts_ff, 6'h00, state_ff, delay_run_ff,
                          protect_open, alarm_active, motor_run};

    // One-second enable pulse from a divider on the core clock.
    // It runs free, so the first second of any delay may be up to one tick short.
    // Simulation shortens the second through the divider parameter.
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end
        else if (tick_cnt_ff >= TICK_CYCLES - 32'h0000_0001)
        begin
            tick_cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b1;
        end
        else
        begin
            tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
            tick_ff <= 1'b0;
        end
    end

    // Configuration registers written by software.
    // Writes to unmapped offsets fall through and change nothing.
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_ff <= {4'h0, `RESTART_MAX_DEFAULT, 4'h0, `FUNC_PROTECT};
            delay_sec_ff <= `DELAY_SEC_DEFAULT;
            restart_sec_ff <= `RESTART_SEC_DEFAULT;
            irq_mask_ff <= 3'h0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `REG_CTRL)
                ctrl_ff <= {4'h0, reg_wdata[11:0]};
            if (reg_addr == `REG_DELAY)
                delay_sec_ff <= reg_wdata;
            if (reg_addr == `REG_RESTART)
                restart_sec_ff <= reg_wdata;
            if (reg_addr == `REG_IRQ_MASK)
                irq_mask_ff <= reg_wdata[2:0];
        end
    end

    // Protection delay timer, restarted whenever the inputs reclose.
    // It is held clear outside the idle state, so a restart begins a fresh delay.
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            delay_run_ff <= 1'b0;
            delay_cnt_ff <= 16'h0000;
        end
        else if (!protect_open || state_ff != ST_IDLE)
        begin
            delay_run_ff <= 1'b0;
            delay_cnt_ff <= 16'h0000;
        end
        else if (!delay_run_ff)
        begin
            delay_run_ff <= 1'b1;
            delay_cnt_ff <= 16'h0000;
        end
        else if (tick_ff && !delay_done)
            delay_cnt_ff <= delay_cnt_ff + 16'h0001;
    end

    // Trip state machine with restart policy.
    // A protection trip goes to the tripped state while restarts remain, else it locks.
    // A trip-lock condition seen in the idle state locks and waits for a manual reset; while tripped it is not looked at.
    always @*
    begin
        nxt_state = state_ff;
        nxt_event = 3'h0;
        nxt_alarm_code = alarm_code;
        case (state_ff)
            ST_IDLE:
            begin
                // A trip-lock condition wins over a protection trip in the same cycle.
                if (trip_lock_alarm)
                begin
                    nxt_state = ST_LOCKED;
                    nxt_alarm_code = `ALARM_TRIPLOCK;
                    nxt_event[`IRQ_LOCKOUT] = 1'b1;
                end
                // The input must still be open when the delay runs out.
                else if (delay_done && protect_open)
                begin
                    nxt_alarm_code = `ALARM_PROTECT;
                    nxt_event[`IRQ_TRIP] = 1'b1;
                    if (may_restart)
                        nxt_state = ST_TRIPPED;
                    else
                    begin
                        nxt_state = ST_LOCKED;
                        nxt_event[`IRQ_LOCKOUT] = 1'b1;
                    end
                end
            end
            ST_TRIPPED:
            begin
                // A manual reset ends the wait early and is not counted as an attempt.
                if (manual_reset)
                    nxt_state = ST_IDLE;
                else if (restart_due)
                begin
                    nxt_state = ST_IDLE;
                    nxt_event[`IRQ_RESTART] = 1'b1;
                end
            end
            ST_LOCKED:
            begin
                // Only a manual reset leaves the locked state.
                if (manual_reset)
                    nxt_state = ST_IDLE;
            end
            default:
                nxt_state = ST_IDLE;
        endcase
        if (nxt_state == ST_IDLE && state_ff != ST_IDLE)
            nxt_alarm_code = 8'h00;
    end

    // State, restart interval counter and attempt counter.
    // Attempts saturate at fifteen so a small allowance can never wrap around.
    // The interval counts from entry into the tripped state.
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= ST_IDLE;
            restart_cnt_ff <= 16'h0000;
            attempts_ff <= 4'h0;
            alarm_code <= 8'h00;
        end
        else
        begin
            state_ff <= nxt_state;
            alarm_code <= nxt_alarm_code;
            if (state_ff != ST_TRIPPED)
                restart_cnt_ff <= 16'h0000;
            else if (tick_ff && !restart_due)
                restart_cnt_ff <= restart_cnt_ff + 16'h0001;
            if (manual_reset)
                attempts_ff <= 4'h0;
            else if (nxt_event[`IRQ_RESTART] && attempts_ff != 4'hF)
                attempts_ff <= attempts_ff + 4'h1;
        end
    end

    // Outputs: motor runs on request unless an alarm holds it off.
    // The motor output looks at the next state, so a trip stops it on the same edge.
    // The interrupt line follows the status one cycle late.
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            motor_run <= 1'b0;
            alarm_active <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            motor_run <= run_request_input && (nxt_state == ST_IDLE);
            alarm_active <= (nxt_state != ST_IDLE);
            irq <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // Sticky interrupt status; a new event wins over a write-one clear.
    // Software must clear a bit after servicing it, or the line stays high.
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_stat_ff <= 3'h0;
        else if (write_hit(reg_wr, reg_addr, `REG_IRQ_STAT))
            irq_stat_ff <= (irq_stat_ff & ~reg_wdata[2:0]) | nxt_event;
        else
            irq_stat_ff <= irq_stat_ff | nxt_event;
    end

    // Read port map, one 16-bit word per offset:
    //   0 control: input A function, input B function, restart allowance, manual reset.
    //   1 protection delay in seconds.
    //   2 restart interval in seconds.
    //   3 status word, read only.
    //   4 interrupt status, write one to clear.
    //   5 interrupt mask.
    //   6 alarm number, zero while no alarm stands.
    // Read data, valid in the cycle after the read strobe only.
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `REG_CTRL: reg_rdata <= ctrl_ff;
                `REG_DELAY: reg_rdata <= delay_sec_ff;
                `REG_RESTART: reg_rdata <= restart_sec_ff;
                `REG_STATUS: reg_rdata <= status_word;
                `REG_IRQ_STAT: reg_rdata <= {13'h0000, irq_stat_ff};
                `REG_IRQ_MASK: reg_rdata <= {13'h0000, irq_mask_ff};
                `REG_ALARM: reg_rdata <= {8'h00, alarm_code};
                default: reg_rdata <= 16'h0000;
            endcase
        end
        else
            reg_rdata <= 16'h0000;
    end

endmodule

`default_nettype wire

// ### hw/pump_protect_regs.vh
// Constants for the pump protection trip and restart block.
`ifndef PUMP_PROTECT_REGS_VH
`define PUMP_PROTECT_REGS_VH

// Input function code that selects the protection trip.
`define FUNC_PROTECT 4'h7
`define FUNC_W 4
// Alarm number raised on a protection trip.
`define ALARM_PROTECT 8'h3C
// Alarm number for a trip-lock alarm input.
`define ALARM_TRIPLOCK 8'hFF
// Default restart allowance, zero means manual reset only.
`define RESTART_MAX_DEFAULT 4'h3
// Default restart interval and protection delay, in seconds.
`define RESTART_SEC_DEFAULT 16'h001E
`define DELAY_SEC_DEFAULT 16'h000A
// Clock rate and cycles per one-second tick.
`define CLK_HZ 50000000
`define TICK_CYCLES (`CLK_HZ / 1)
// Register map of the plain register port.
`define REG_CTRL 4'h0
`define REG_DELAY 4'h1
`define REG_RESTART 4'h2
`define REG_STATUS 4'h3
`define REG_IRQ_STAT 4'h4
`define REG_IRQ_MASK 4'h5
`define REG_ALARM 4'h6
// Control field positions.
`define CTRL_FUNC_A_LSB 0
`define CTRL_FUNC_B_LSB 4
`define CTRL_MAX_LSB 8
`define CTRL_MANUAL_RESET 12
// Interrupt bits.
`define IRQ_TRIP 0
`define IRQ_RESTART 1
`define IRQ_LOCKOUT 2

`endif

// ### dv/pump_protect_props.sv
// Port assertions and covers for the pump protection trip and restart block.
`timescale 1ns/1ps
`default_nettype none
module pump_protect_props (
    input wire core_clk,
    input wire rst_n,
    input wire run_request_input,
    input wire protect_input_a,
    input wire protect_input_b,
    input wire trip_lock_alarm,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire motor_run,
    input wire alarm_active,
    input wire [7:0] alarm_code,
    input wire irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Run permit, trip outcome and restart spacing seen at the ports.
    AST_RUN_STOP: assert property (!run_request_input |=> !motor_run)
        else $error("motor runs with no request");
    AST_RUN_START: assert property (run_request_input && !alarm_active && !trip_lock_alarm
        && protect_input_a && protect_input_b |=> motor_run)
        else $error("request did not start the motor");
    AST_ALARM_STOP: assert property (alarm_active |-> !motor_run)
        else $error("motor runs during an alarm");
    AST_CODE: assert property ($rose(alarm_active) && !$past(trip_lock_alarm)
        |-> alarm_code == 8'h3C)
        else $error("trip alarm code wrong");
    AST_OPEN_CAUSE: assert property ($rose(alarm_active) && !$past(trip_lock_alarm)
        |-> !$past(protect_input_a) || !$past(protect_input_b))
        else $error("trip with all inputs closed");
    AST_LOCK: assert property ($rose(trip_lock_alarm) |-> ##[1:2] alarm_active)
        else $error("trip-lock alarm not raised");
    AST_HOLD: assert property ($rose(alarm_active) |-> alarm_active[*8])
        else $error("restart came too soon");
    AST_MRESET: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[12]
        && protect_input_a && protect_input_b && !trip_lock_alarm |-> ##[1:2] !alarm_active)
        else $error("manual reset did not clear the alarm");
    COV_TRIP: cover property ($rose(alarm_active) && alarm_code == 8'h3C);
    COV_RESTART: cover property ($fell(alarm_active) && !reg_wr);
    COV_IRQ: cover property ($rose(irq));
endmodule
bind pump_protect_trip_restart pump_protect_props pump_protect_props_inst (
    .core_clk(core_clk), .rst_n(rst_n), .run_request_input(run_request_input),
    .protect_input_a(protect_input_a), .protect_input_b(protect_input_b),
    .trip_lock_alarm(trip_lock_alarm), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .motor_run(motor_run),
    .alarm_active(alarm_active), .alarm_code(alarm_code), .irq(irq));
`default_nettype wire

// ### dv/field_contacts.sv
// Field contact model for the run request and protection inputs.
`timescale 1ns/1ps
`default_nettype none
module field_contacts (
    input wire logic core_clk,
    input wire logic start_closed,
    input wire logic fault_a,
    input wire logic fault_b,
    input wire logic lock_fault,
    output logic run_level,
    output logic prot_a_level,
    output logic prot_b_level,
    output logic lock_level
);
    // The no-water restart jumper is a fixed link outside the block, with no line here.
    // Contacts settle one clock after the bench moves them.
    always @(posedge core_clk)
    begin
        run_level <= start_closed;
        prot_a_level <= !fault_a; // A fault opens the normally closed switch.
        prot_b_level <= !fault_b;
        lock_level <= lock_fault;
    end
endmodule
`default_nettype wire

// ### dv/test_pump_protect_trip_restart.sv
// Self-checking bench for the pump protection trip and restart block.
`include "pump_protect_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module test_pump_protect_trip_restart;
    logic core_clk, rst_n, reg_wr, reg_rd, want_run, open_a, open_b, lock;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, rv;
    logic [3:0] ra [5] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'hF};
    logic [15:0] rx [5] = '{16'h0307, 16'h000A, 16'h001E, 16'h0000, 16'h0000};
    wire run_i, pa_i, pb_i, lk_i, motor_run, alarm_active, irq;
    wire [7:0] alarm_code;
    wire [15:0] reg_rdata;
    int n_mismatch = 0, total_checks = 0, cycles = 0, len;
    field_contacts field_contacts_inst (.core_clk(core_clk), .start_closed(want_run),
        .fault_a(open_a), .fault_b(open_b), .lock_fault(lock), .run_level(run_i),
        .prot_a_level(pa_i), .prot_b_level(pb_i), .lock_level(lk_i));
    pump_protect_trip_restart #(.TICK_CYCLES(32'h0000_000A)) pump_protect_trip_restart_inst (
        .core_clk(core_clk), .rst_n(rst_n), .run_request_input(run_i),
        .protect_input_a(pa_i), .protect_input_b(pb_i), .trip_lock_alarm(lk_i),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .motor_run(motor_run), .alarm_active(alarm_active),
        .alarm_code(alarm_code), .irq(irq));
    // Clock and hang guard.
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            stop_test();
        end
    end
    // Comparison and bus cycles shared by all tests, and the trip sequence of tests 3 and 4.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task automatic wait_alarm(input logic v, input int n);
        #1;
        for (int i = 0; i < n && alarm_active !== v; i++)
        begin
            @(posedge core_clk);
            #1;
        end
        check(16'(alarm_active), 16'(v));
    endtask
    task automatic trip(input logic use_b);
        @(posedge core_clk);
        open_a <= !use_b;
        open_b <= use_b;
        @(posedge core_clk);
        rd(`REG_STATUS);
        check(16'(rv[3:2]), 16'h0003);
        wait_alarm(1'b1, 50);
        check(16'(alarm_code), 16'h003C);
        check(16'(motor_run), 16'h0000);
        rd(`REG_ALARM);
        check(rv, 16'h003C);
        @(posedge core_clk);
        open_a <= 1'b0;
        open_b <= 1'b0;
    endtask
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence: reset values, run permit, glitch, restarts, input B, trip-lock.
    initial
    begin
        {reg_wr, reg_rd, want_run, open_a, open_b, lock, rst_n} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        rv = $urandom(32557);
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (ra[i])
        begin
            rd(ra[i]);
            check(rv, rx[i]);
        end
        $display("test 1 done");
        repeat (8)
        begin
            @(posedge core_clk);
            want_run <= 1'($urandom);
            repeat (3) @(posedge core_clk);
            #1 check(16'(motor_run), 16'(want_run));
        end
        want_run <= 1'b1;
        wr(`REG_DELAY, 16'h0003);
        wr(`REG_RESTART, 16'h0002);
        wr(`REG_IRQ_MASK, 16'h0007);
        @(posedge core_clk);
        open_a <= 1'b1;
        len = 2 + $urandom % 14;
        repeat (len) @(posedge core_clk);
        open_a <= 1'b0;
        repeat (40) @(posedge core_clk);
        #1 check(16'(alarm_active), 16'h0000);
        $display("test 2 done");
        for (int i = 1; i <= 4; i++)
        begin
            trip(1'b0);
            #1 check(16'(irq), 16'h0001);
            rd(`REG_STATUS);
            check(16'(rv[5:4]), (i < 4) ? 16'h0001 : 16'h0002);
            wr(`REG_IRQ_STAT, 16'h0007);
            if (i < 4)
                wait_alarm(1'b0, 40);
            rd(`REG_STATUS);
            check(16'(rv[15:12]), 16'(i - (i / 4)));
        end
        wr(`REG_CTRL, 16'h1307);
        rd(`REG_STATUS);
        check(rv, 16'h0001);
        $display("test 3 done");
        wr(`REG_CTRL, 16'h0070);
        wr(`REG_IRQ_MASK, 16'h0000);
        @(posedge core_clk);
        open_a <= 1'b1;
        repeat (60) @(posedge core_clk);
        open_a <= 1'b0;
        #1 check(16'(alarm_active), 16'h0000);
        trip(1'b1);
        repeat (60) @(posedge core_clk);
        rd(`REG_STATUS);
        check(16'(rv[5:4]), 16'h0002);
        check(16'(irq), 16'h0000);
        rd(`REG_IRQ_STAT);
        check(16'(rv[2]), 16'h0001);
        wr(`REG_CTRL, 16'h1307);
        wait_alarm(1'b0, 5);
        $display("test 4 done");
        @(posedge core_clk);
        lock <= 1'b1;
        wait_alarm(1'b1, 5);
        check(16'(alarm_code), 16'h00FF);
        repeat (60) @(posedge core_clk);
        #1 check(16'(alarm_active), 16'h0001);
        @(posedge core_clk);
        lock <= 1'b0;
        wr(`REG_CTRL, 16'h1070);
        wait_alarm(1'b0, 5);
        $display("test 5 done");
        stop_test();
    end
endmodule
`default_nettype wire
